// ===== design/cfgt_pkg.sv
// Constants, field layout and carrier types of the configuration-2 lower field block
package cfgt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  CFG2_IDX       = 8'h02;
    localparam logic [7:0]  START_IDX      = 8'h03;
    localparam logic [7:0]  STAT1_IDX      = 8'h10;
    localparam logic [7:0]  STAT2_IDX      = 8'h11;
    localparam logic [7:0]  MASK_IDX       = 8'h12;
    localparam logic [7:0]  STAMP_IDX      = 8'h13;
    localparam logic [7:0]  AUX_IDX        = 8'h14;
    localparam int          ADDR_W         = 10;

    // Configuration-2 field positions
    localparam int          DBL_BIT        = 12;
    localparam int          TICK_LSB       = 7;
    localparam int          SYNC_CLR_BIT   = 6;
    localparam int          SYNC_LOAD_BIT  = 5;
    localparam int          CLR_READ_BIT   = 4;
    localparam int          LEVEL_BIT      = 3;
    localparam int          SRV_AUTO_BIT   = 2;
    localparam int          PER_SA_BIT     = 1;
    localparam int          BCAST_SEP_BIT  = 0;
    localparam logic [31:0] CFG2_RW_MASK   = 32'h000013ff;
    localparam logic [12:0] CFG2_RESET     = 13'h0000;

    // Start/reset write bits
    localparam int          START_INC_BIT  = 4;
    localparam int          START_RST_BIT  = 3;
    localparam int          START_CLR_BIT  = 2;

    // Auxiliary register bits
    localparam int          AUX_SEND_BIT   = 0;
    localparam int          AUX_SRV_BIT    = 1;

    // Tick select codes
    localparam logic [2:0]  TICK_HOST      = 3'h6;
    localparam logic [2:0]  TICK_EXT       = 3'h7;
    localparam logic [2:0]  TICK_FIXED_MAX = 3'h5;

    // Internal status event bits of status register 1
    localparam int          EV_SYNC        = 0;
    localparam int          EV_SYNC_LOAD   = 1;
    localparam int          EV_VECTOR      = 2;
    localparam int          EV_WRAP        = 3;

    // Timing
    localparam int          CLK_MHZ        = 250;
    localparam int          TICK_MIN_US    = 2;
    localparam int          TICK_MIN_CYC   = TICK_MIN_US * CLK_MHZ;
    localparam int          IRQ_PULSE_NS   = 500;
    localparam int          IRQ_PULSE_CYC  = (IRQ_PULSE_NS * CLK_MHZ) / 1000;

    typedef struct packed {
        logic       global_double_buffer;
        logic [1:0] unused_hi;
        logic [2:0] stamp_tick_select;
        logic       stamp_clear_on_sync;
        logic       stamp_load_on_sync_data;
        logic       status_clear_on_read;
        logic       irq_level_style;
        logic       service_bit_auto_clear;
        logic       per_subaddr_buffering;
        logic       broadcast_separate_store;
    } cfgt_cfg_s;

    typedef struct packed {
        logic        sync_rx;
        logic        sync_data_rx;
        logic [15:0] sync_data;
        logic        vector_answered;
        logic        sync_tx_req;
    } cfgt_bus_ev_s;

    typedef struct packed {
        logic rx_double_buffer;
        logic rx_store_separate;
    } cfgt_buf_s;
endpackage : cfgt_pkg

// ===== design/cfgt_top.sv
// Configuration-2 lower fields: stamp counter, interrupt status/output, service bit, buffer steering
`timescale 1ns/10ps
module cfgt_top #(
    parameter int TICK_2US_CYCLES = cfgt_pkg::TICK_MIN_CYC,
    parameter int PULSE_CYCLES    = cfgt_pkg::IRQ_PULSE_CYC
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [cfgt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      rt_mode,
    input  wire logic                      stamp_ext_clk,
    input  wire cfgt_pkg::cfgt_bus_ev_s    bus_ev,
    input  wire logic [15:0]               evt_grp1,
    input  wire logic [15:0]               evt_grp2,
    input  wire logic                      rx_broadcast,
    input  wire logic                      rx_subaddr_double,
    output cfgt_pkg::cfgt_buf_s            buf_ctl,
    output logic [15:0]                    sync_tx_word,
    output logic                           sync_tx_from_stamp,
    output logic                           service_request,
    output logic [15:0]                    stamp_count,
    output logic                           int_n
);
    import cfgt_pkg::*;

    localparam int PRE_W = 16;

    initial begin
        if (TICK_2US_CYCLES < 1 || (TICK_2US_CYCLES << 5) >= (1 << PRE_W)) begin
            $error("TICK_2US_CYCLES out of range");
        end
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin
            $error("PULSE_CYCLES out of range");
        end
    end

    cfgt_cfg_s         cfg_r;
    logic              send_stamp_r;
    logic [15:0]       stat1_r;
    logic [15:0]       stat2_r;
    logic [31:0]       mask_r;
    logic [PRE_W-1:0]  pre_r;
    logic              ext_d_r;
    logic [7:0]        pulse_r;

    // Bus decode
    logic              acc;
    logic              wr;
    logic              rd;
    logic [7:0]        idx;
    logic              mapped;

    assign idx     = paddr[ADDR_W-1:2];
    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign rd      = acc && !pwrite;
    assign mapped  = (paddr[1:0] == 2'h0) &&
                     (idx == CFG2_IDX || idx == START_IDX || idx == STAT1_IDX || idx == STAT2_IDX ||
                      idx == MASK_IDX || idx == STAMP_IDX || idx == AUX_IDX);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    logic wr_cfg;
    logic wr_start;
    logic wr_mask;
    logic wr_aux;
    logic rd_stat1;
    logic rd_stat2;

    assign wr_cfg   = wr && mapped && idx == CFG2_IDX;
    assign wr_start = wr && mapped && idx == START_IDX;
    assign wr_mask  = wr && mapped && idx == MASK_IDX;
    assign wr_aux   = wr && mapped && idx == AUX_IDX;
    assign rd_stat1 = rd && mapped && idx == STAT1_IDX;
    assign rd_stat2 = rd && mapped && idx == STAT2_IDX;

    // Configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= cfgt_cfg_s'(CFG2_RESET);
        end else if (wr_cfg) begin
            cfg_r <= cfgt_cfg_s'(pwdata[12:0] & CFG2_RW_MASK[12:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            send_stamp_r <= 1'b0;
        end else if (wr_aux) begin
            send_stamp_r <= pwdata[AUX_SEND_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 32'h00000000;
        end else if (wr_mask) begin
            mask_r <= pwdata;
        end
    end

    // Stamp tick generation
    logic [PRE_W-1:0] period;
    logic             fixed_tick;
    logic             host_tick;
    logic             ext_tick;
    logic             tick;

    always_comb begin
        period = PRE_W'(TICK_2US_CYCLES) << (3'h5 - cfg_r.stamp_tick_select);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= '0;
        end else if (cfg_r.stamp_tick_select > TICK_FIXED_MAX || wr_cfg || pre_r >= period - 1'b1) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= stamp_ext_clk;
        end
    end

    assign fixed_tick = cfg_r.stamp_tick_select <= TICK_FIXED_MAX && !wr_cfg
                        && pre_r >= period - 1'b1;
    assign host_tick  = cfg_r.stamp_tick_select == TICK_HOST && wr_start
                        && pwdata[START_INC_BIT];
    assign ext_tick   = cfg_r.stamp_tick_select == TICK_EXT && stamp_ext_clk && !ext_d_r;
    assign tick       = fixed_tick || host_tick || ext_tick;

    // Stamp counter: reset and sync actions take precedence over a tick
    logic sync_clear;
    logic sync_load;
    logic wrap;

    assign sync_clear = cfg_r.stamp_clear_on_sync && bus_ev.sync_rx;
    assign sync_load  = rt_mode && cfg_r.stamp_load_on_sync_data && bus_ev.sync_data_rx;
    assign wrap       = tick && stamp_count == 16'hffff && !sync_clear && !sync_load;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stamp_count <= 16'h0000;
        end else if (wr_start && pwdata[START_RST_BIT]) begin
            stamp_count <= 16'h0000;
        end else if (sync_load) begin
            stamp_count <= bus_ev.sync_data;
        end else if (sync_clear) begin
            stamp_count <= 16'h0000;
        end else if (tick) begin
            stamp_count <= stamp_count + 16'h0001;
        end
    end

    // Word for an issued Synchronize With Data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_tx_word       <= 16'h0000;
            sync_tx_from_stamp <= 1'b0;
        end else if (bus_ev.sync_tx_req) begin
            sync_tx_from_stamp <= send_stamp_r;
            sync_tx_word       <= send_stamp_r ? stamp_count : 16'h0000;
        end
    end

    // Service request bit: a host write wins over the automatic clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            service_request <= 1'b0;
        end else if (wr_aux) begin
            service_request <= pwdata[AUX_SRV_BIT];
        end else if (cfg_r.service_bit_auto_clear && bus_ev.vector_answered) begin
            service_request <= 1'b0;
        end
    end

    // Interrupt status: new events win over any clear in the same cycle
    logic [15:0] ev1;
    logic        clr_both;
    logic        clr1;
    logic        clr2;

    always_comb begin
        ev1               = evt_grp1;
        ev1[EV_SYNC]      = evt_grp1[EV_SYNC] | bus_ev.sync_rx;
        ev1[EV_SYNC_LOAD] = evt_grp1[EV_SYNC_LOAD] | sync_load;
        ev1[EV_VECTOR]    = evt_grp1[EV_VECTOR] | bus_ev.vector_answered;
        ev1[EV_WRAP]      = evt_grp1[EV_WRAP] | wrap;
    end

    assign clr_both = !cfg_r.status_clear_on_read && wr_start && pwdata[START_CLR_BIT];
    assign clr1     = clr_both || (cfg_r.status_clear_on_read && rd_stat1);
    assign clr2     = clr_both || (cfg_r.status_clear_on_read && rd_stat2);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat1_r <= 16'h0000;
        end else begin
            stat1_r <= (clr1 ? 16'h0000 : stat1_r) | ev1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat2_r <= 16'h0000;
        end else begin
            stat2_r <= (clr2 ? 16'h0000 : stat2_r) | evt_grp2;
        end
    end

    // Interrupt output, active low
    logic pending;
    logic fresh;

    assign pending = |({stat2_r, stat1_r} & mask_r);
    assign fresh   = |({evt_grp2, ev1} & mask_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= 8'h00;
        end else if (cfg_r.irq_level_style) begin
            pulse_r <= 8'h00;
        end else if (fresh && pulse_r == 8'h00) begin
            pulse_r <= 8'(PULSE_CYCLES);
        end else if (pulse_r != 8'h00) begin
            pulse_r <= pulse_r - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_n <= 1'b1;
        end else if (cfg_r.irq_level_style) begin
            int_n <= !pending;
        end else begin
            int_n <= !((fresh && pulse_r == 8'h00) || pulse_r > 8'h01);
        end
    end

    // Receive buffer steering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_ctl <= '0;
        end else begin
            buf_ctl.rx_double_buffer  <= cfg_r.per_subaddr_buffering ? rx_subaddr_double
                                                                     : cfg_r.global_double_buffer;
            buf_ctl.rx_store_separate <= cfg_r.broadcast_separate_store && rx_broadcast;
        end
    end

    // Read data, captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (idx)
                CFG2_IDX:  prdata <= {19'h00000, cfg_r} & CFG2_RW_MASK;
                STAT1_IDX: prdata <= {16'h0000, stat1_r};
                STAT2_IDX: prdata <= {16'h0000, stat2_r};
                MASK_IDX:  prdata <= mask_r;
                STAMP_IDX: prdata <= {16'h0000, stamp_count};
                AUX_IDX:   prdata <= {30'h00000000, service_request, send_stamp_r};
                default:   prdata <= 32'h00000000;
            endcase
        end
    end
endmodule : cfgt_top

// ===== bench/cfgt_props.sv
// Checker of configuration-2 field effects at the block ports
`timescale 1ns/10ps
module cfgt_props #(
    parameter int PULSE_CYCLES = 125
) (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [cfgt_pkg::ADDR_W-1:0]   paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [31:0]                   prdata,
    input wire logic                          rt_mode,
    input wire cfgt_pkg::cfgt_bus_ev_s        bus_ev,
    input wire logic                          rx_broadcast,
    input wire logic                          rx_subaddr_double,
    input wire cfgt_pkg::cfgt_buf_s           buf_ctl,
    input wire logic [15:0]                   sync_tx_word,
    input wire logic                          sync_tx_from_stamp,
    input wire logic                          service_request,
    input wire logic [15:0]                   stamp_count,
    input wire logic                          int_n
);
    import cfgt_pkg::*;
    logic [12:0] cfg_r;
    logic        send_r;
    logic [7:0]  low_r;
    logic        acc;
    logic        dbl_x;
    assign acc = psel && penable;
    assign dbl_x = cfg_r[PER_SA_BIT] ? rx_subaddr_double : cfg_r[DBL_BIT];
    // Shadow of the host-written settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cfg_r <= 13'h0;
        else if (acc && pwrite && paddr == 10'h008) cfg_r <= pwdata[12:0] & 13'h13ff;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) send_r <= 1'b0;
        else if (acc && pwrite && paddr == 10'h050) send_r <= pwdata[AUX_SEND_BIT];
    end
    // Length of the current low run of the interrupt output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_r <= 8'h0;
        else if (int_n) low_r <= 8'h0;
        else if (low_r != 8'hff) low_r <= low_r + 8'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_load; bus_ev.sync_data_rx && rt_mode && cfg_r[SYNC_LOAD_BIT] && !acc; endsequence
    property p_dbl; 1'b1 |=> buf_ctl.rx_double_buffer == $past(dbl_x); endproperty
    a_dbl: assert property (p_dbl) else $error("double buffer select wrong");
    property p_sep; rx_broadcast |=> buf_ctl.rx_store_separate == $past(cfg_r[BCAST_SEP_BIT]); endproperty
    a_sep: assert property (p_sep) else $error("broadcast store select wrong");
    property p_cfg; acc && !pwrite && paddr == 10'h008 |-> prdata == {19'h0, cfg_r}; endproperty
    a_cfg: assert property (p_cfg) else $error("settings readback wrong");
    property p_load; s_load |=> stamp_count == $past(bus_ev.sync_data); endproperty
    a_load: assert property (p_load) else $error("sync data not loaded");
    property p_clr; bus_ev.sync_rx && cfg_r[SYNC_CLR_BIT] && !bus_ev.sync_data_rx && !acc |=> stamp_count == 16'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("stamp not cleared on sync");
    property p_send; bus_ev.sync_tx_req && send_r |=> sync_tx_from_stamp && sync_tx_word == $past(stamp_count);
    endproperty
    a_send: assert property (p_send) else $error("sync word not stamp");
    property p_pulse; $rose(int_n) && !cfg_r[LEVEL_BIT] |-> low_r == PULSE_CYCLES; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length wrong");
    property p_srv; bus_ev.vector_answered && cfg_r[SRV_AUTO_BIT] && !acc |=> !service_request; endproperty
    a_srv: assert property (p_srv) else $error("service bit not auto cleared");
    property p_srvh; !cfg_r[SRV_AUTO_BIT] && !acc |=> $stable(service_request); endproperty
    a_srvh: assert property (p_srvh) else $error("service bit changed without host");
endmodule : cfgt_props

// ===== bench/cfgt_host.sv
// Host processor model: APB master issuing register transfers
`timescale 1ns/10ps
module cfgt_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        // Released data no longer shows the last value
        {psel, penable, pwdata} <= {2'b00, ~d};
        @(posedge pclk);
    endtask : xfer
endmodule : cfgt_host

// ===== bench/cfgt_top_tb.sv
// Self-checking testbench of the configuration-2 field block
`timescale 1ns/10ps
module cfgt_top_tb;
    import cfgt_pkg::*;
    localparam int TK = 4;
    localparam int PC = 3;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         rt_mode = 1'b0;
    logic         stamp_ext_clk = 1'b0;
    logic         rx_broadcast = 1'b0;
    logic         rx_subaddr_double = 1'b0;
    logic [15:0]  evt_grp1 = 16'h0;
    logic [15:0]  evt_grp2 = 16'h0;
    cfgt_bus_ev_s bus_ev = '0;
    logic         psel, penable, pwrite, pready, pslverr, sync_tx_from_stamp, service_request, int_n, er;
    logic [9:0]   paddr;
    logic [31:0]  pwdata, prdata, rd, a;
    logic [15:0]  sync_tx_word, stamp_count;
    cfgt_buf_s    buf_ctl;
    int           fails = 0;
    int           compares = 0;
    int           n;
    cfgt_top #(.TICK_2US_CYCLES(TK), .PULSE_CYCLES(PC)) i_cfgt_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rt_mode(rt_mode),
        .stamp_ext_clk(stamp_ext_clk), .bus_ev(bus_ev), .evt_grp1(evt_grp1), .evt_grp2(evt_grp2),
        .rx_broadcast(rx_broadcast), .rx_subaddr_double(rx_subaddr_double), .buf_ctl(buf_ctl),
        .sync_tx_word(sync_tx_word), .sync_tx_from_stamp(sync_tx_from_stamp),
        .service_request(service_request), .stamp_count(stamp_count), .int_n(int_n));
    cfgt_host i_cfgt_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial forever #2 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        @(negedge pclk);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
        @(posedge pclk);
    endtask : chk
    task automatic wr(input logic [9:0] ad, input logic [31:0] d);
        i_cfgt_host.xfer(1'b1, ad, d, rd, er);
    endtask : wr
    task automatic rc(input logic [9:0] ad, input logic [31:0] e);
        i_cfgt_host.xfer(1'b0, ad, 32'h0, rd, er);
        chk(rd, e);
    endtask : rc
    task automatic ev(input logic [19:0] v, input logic [15:0] g1, input logic [15:0] g2);
        {bus_ev, evt_grp1, evt_grp2} <= {v, g1, g2};
        @(posedge pclk);
        {bus_ev, evt_grp1, evt_grp2} <= '0;
        repeat (2) @(posedge pclk);
    endtask : ev
    task automatic t_regs;
        rc(10'h008, 32'h0);
        wr(10'h008, 32'hffffffff);
        rc(10'h008, 32'h000013ff);
        rc(10'h3fc, 32'h0);
        chk(er, 1'b1);
    endtask : t_regs
    task automatic t_tick;
        wr(10'h008, 32'h300);
        wr(10'h00c, 32'h8);
        wr(10'h00c, 32'h10);
        wr(10'h00c, 32'h10);
        rc(10'h04c, 32'h2);
        wr(10'h008, 32'h380);
        repeat (3) begin
            stamp_ext_clk <= 1'b1;
            repeat (2) @(posedge pclk);
            stamp_ext_clk <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        rc(10'h04c, 32'h5);
        for (int c = 0; c < 6; c++) begin
            wr(10'h008, c << 7);
            i_cfgt_host.xfer(1'b0, 10'h04c, 32'h0, a, er);
            repeat (((2 * TK) << (5 - c)) - 3) @(posedge pclk);
            rc(10'h04c, a + 32'h2);
        end
    endtask : t_tick
    task automatic t_sync;
        wr(10'h008, 32'h360);
        wr(10'h050, 32'h1);
        rt_mode <= 1'b1;
        ev({2'b01, 16'ha5c3, 2'b00}, 16'h0, 16'h0);
        rc(10'h04c, 32'ha5c3);
        ev(20'h1, 16'h0, 16'h0);
        chk(sync_tx_word, 32'ha5c3);
        chk(sync_tx_from_stamp, 1'b1);
        rt_mode <= 1'b0;
        ev({2'b01, 16'h1234, 2'b00}, 16'h0, 16'h0);
        rc(10'h04c, 32'ha5c3);
        ev(20'h80000, 16'h0, 16'h0);
        rc(10'h04c, 32'h0);
    endtask : t_sync
    task automatic t_irq;
        wr(10'h048, 32'h00010100);
        wr(10'h008, 32'h318);
        i_cfgt_host.xfer(1'b0, 10'h040, 32'h0, rd, er);
        i_cfgt_host.xfer(1'b0, 10'h044, 32'h0, rd, er);
        ev(20'h0, 16'h0200, 16'h0);
        chk(int_n, 1'b1);
        ev(20'h0, 16'h0100, 16'h0001);
        chk(int_n, 1'b0);
        rc(10'h040, 32'h300);
        chk(int_n, 1'b0);
        rc(10'h044, 32'h1);
        chk(int_n, 1'b1);
        wr(10'h008, 32'h308);
        ev(20'h0, 16'h0100, 16'h0);
        rc(10'h040, 32'h100);
        rc(10'h040, 32'h100);
        chk(int_n, 1'b0);
        wr(10'h00c, 32'h4);
        rc(10'h040, 32'h0);
        chk(int_n, 1'b1);
        wr(10'h008, 32'h300);
        evt_grp1 <= 16'h0100;
        @(posedge pclk);
        evt_grp1 <= 16'h0;
        n = 0;
        repeat (10) begin
            @(negedge pclk);
            n += (int_n === 1'b0);
        end
        chk(n, PC);
        wr(10'h00c, 32'h4);
    endtask : t_irq
    task automatic t_srv;
        wr(10'h050, 32'h2);
        chk(service_request, 1'b1);
        ev(20'h2, 16'h0, 16'h0);
        chk(service_request, 1'b1);
        wr(10'h008, 32'h304);
        ev(20'h2, 16'h0, 16'h0);
        chk(service_request, 1'b0);
    endtask : t_srv
    task automatic t_buf;
        for (int i = 0; i < 32; i++) begin
            wr(10'h008, {19'h0, i[0], 10'h0, i[1], i[3]});
            rx_subaddr_double <= i[2];
            rx_broadcast <= i[4];
            repeat (2) @(posedge pclk);
            chk(buf_ctl.rx_double_buffer, i[1] ? i[2] : i[0]);
            if (i[4]) chk(buf_ctl.rx_store_separate, i[3]);
        end
    endtask : t_buf
    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_tick();
        t_sync();
        t_irq();
        t_srv();
        t_buf();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test();
    end
endmodule : cfgt_top_tb
bind cfgt_top cfgt_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_cfgt_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .rt_mode(rt_mode), .bus_ev(bus_ev), .rx_broadcast(rx_broadcast), .rx_subaddr_double(rx_subaddr_double),
    .buf_ctl(buf_ctl), .sync_tx_word(sync_tx_word), .sync_tx_from_stamp(sync_tx_from_stamp),
    .service_request(service_request), .stamp_count(stamp_count), .int_n(int_n));
